// ===== include/hdg_pkg.sv
// Package for the host decode and interrupt glue block
package hdg_pkg;
   localparam int HDG_ADDR_W = 10;
   localparam int HDG_NUM_IRQ = 8;
   localparam int HDG_NUM_SRC = 8;
   // Disk alternate status sits at offset 6 of the second base
   localparam logic [9:0] HDG_ALTSTAT_OFS = 10'h006;
   localparam logic [9:0] HDG_CTRL_MASK = 10'h3f8;
   localparam logic [9:0] HDG_EXCL_A = 10'h377;
   localparam logic [9:0] HDG_EXCL_B = 10'h3f7;
   // Shared-interrupt low pulse length
   localparam int HDG_PULSE_NS = 100;
   localparam int HDG_CLK_NS = 10;
   localparam int HDG_PULSE_CYC = (HDG_PULSE_NS + HDG_CLK_NS - 1) / HDG_CLK_NS;
   localparam logic [7:0] HDG_PULSE_CYC8 = 8'(HDG_PULSE_CYC);
   // Route code of an unrouted line
   localparam logic [3:0] HDG_ROUTE_NONE = 4'h0;
   localparam logic [3:0] HDG_ROUTE_EXT = 4'h9;
   typedef enum logic [1:0] {
      HDG_BLK_1 = 2'b00,
      HDG_BLK_8 = 2'b01,
      HDG_BLK_16 = 2'b10
   } hdg_blk_t;
   typedef struct packed {
      logic [9:0] addr;
      logic aen;
   } hdg_hbus_t;
   typedef struct packed {
      logic disk_en;
      logic [9:0] disk_base1;
      logic [9:0] disk_base2;
      logic aux_en;
      logic [9:0] aux_base;
      hdg_blk_t aux_size;
      logic par_shared;
   } hdg_cfg_t;
   typedef struct packed {
      logic o;
      logic oe;
   } hdg_pin_t;
endpackage : hdg_pkg

// ===== src/hdg_irq_pulse.sv
// Pulse shaper for one shared interrupt line
`timescale 1ns/1ns
module hdg_irq_pulse (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic shared_mode,
   input wire logic req,
   // Pin drive
   output hdg_pkg::hdg_pin_t pin
);
   import hdg_pkg::*;
   logic req_q;
   logic [7:0] cnt;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 8'h00;
      end else if (shared_mode && req && !req_q) begin
         cnt <= HDG_PULSE_CYC8;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
   // Shared mode drives low briefly then releases
   always_comb begin
      if (shared_mode) begin
         pin.o = 1'b0;
         pin.oe = (cnt != 8'h00);
      end else begin
         pin.o = req;
         pin.oe = 1'b1;
      end
   end
   // Pulse length checked through the counter, not a long repetition
   a_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
      shared_mode && req && !req_q |=> cnt == HDG_PULSE_CYC8)
      else $error("shared interrupt pulse too short");
   a_pulse_count: assert property (@(posedge clk) disable iff (!rst_n)
      cnt != 8'h00 && !(shared_mode && req && !req_q) |=> cnt == $past(cnt) - 8'h01)
      else $error("shared interrupt pulse counter skipped");
   a_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
      shared_mode && cnt != 8'h00 |-> pin.oe && !pin.o)
      else $error("shared interrupt pulse not driven low");
   a_pulse_end: assert property (@(posedge clk) disable iff (!rst_n)
      (shared_mode && cnt == 8'h01) |=> !pin.oe || $rose(req_q) || cnt != 8'h00)
      else $error("shared interrupt not released");
endmodule : hdg_irq_pulse

// ===== src/hdg_glue.sv
// Host address decode, interrupt steering and power-valid gating
// Operation
// - Disk enable only when enabled and addressed
// - Control chip select covers eight base addresses
// - Alternate chip select covers alternate status
// - Disk selects never decode 377 or 3F7
// - Each line carries routed source or external
// - External interrupt routable to any line
// - EPP/ECP interrupt pulses low then releases
// - Aux decode for 1, 8, 16 byte block
// - Power invalid: ignore inputs, float outputs
// - Host side sync registers keep contents while power invalid
// - Ring indicate and serial interrupt stay alive
`timescale 1ns/1ns
module hdg_glue (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Power and host bus pins
   input wire logic power_valid,
   input hdg_pkg::hdg_hbus_t hbus,
   // Configuration
   input hdg_pkg::hdg_cfg_t cfg,
   input wire logic [7:0][3:0] irq_route,
   // Logical function requests; source 0 is the parallel port
   input wire logic [7:0] func_irq,
   input wire logic ext_interrupt_in,
   input wire logic ring_indicate,
   input wire logic [7:0] serial_irq_mask,
   // Decode outputs
   output hdg_pkg::hdg_pin_t disk_if_enable_n,
   output hdg_pkg::hdg_pin_t disk_cs_ctrl_n,
   output hdg_pkg::hdg_pin_t disk_cs_altstat_n,
   output hdg_pkg::hdg_pin_t aux_block_decode_n,
   // Interrupt lines A to H
   output hdg_pkg::hdg_pin_t [7:0] irq_line,
   // Power state
   output logic low_power,
   output logic ring_seen
);
   import hdg_pkg::*;
   logic pv_s1, pv_s2;
   logic aen_s1, aen_s2;
   logic [9:0] addr_s1, addr_s2;
   logic ext_s1, ext_s2;
   logic ri_s1, ri_s2;
   logic hit_ctrl, hit_alt, excl, aux_hit;
   logic cs_ctrl, cs_alt, aux_dec;
   logic [9:0] aux_mask;
   logic [7:0] sel_req;
   logic [7:0] line_used;
   hdg_pin_t [7:0] shaped;
   // Pins from outside pass two flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pv_s1 <= 1'b0;
         pv_s2 <= 1'b0;
         ri_s1 <= 1'b0;
         ri_s2 <= 1'b0;
      end else begin
         pv_s1 <= power_valid;
         pv_s2 <= pv_s1;
         ri_s1 <= ring_indicate;
         ri_s2 <= ri_s1;
      end
   end
   // Host side inputs frozen while power invalid
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aen_s1 <= 1'b1;
         aen_s2 <= 1'b1;
         addr_s1 <= 10'h000;
         addr_s2 <= 10'h000;
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
      end else if (pv_s2) begin
         aen_s1 <= hbus.aen;
         aen_s2 <= aen_s1;
         addr_s1 <= hbus.addr;
         addr_s2 <= addr_s1;
         ext_s1 <= ext_interrupt_in;
         ext_s2 <= ext_s1;
      end
   end
   // Zero base means not yet programmed
   assign excl = (addr_s2 == HDG_EXCL_A) || (addr_s2 == HDG_EXCL_B);
   assign hit_ctrl = ((addr_s2 & HDG_CTRL_MASK) == cfg.disk_base1)
                     && (cfg.disk_base1 != 10'h000);
   assign hit_alt = (addr_s2 == 10'(cfg.disk_base2 + HDG_ALTSTAT_OFS))
                    && (cfg.disk_base2 != 10'h000);
   assign cs_ctrl = cfg.disk_en && !aen_s2 && hit_ctrl && !excl;
   assign cs_alt = cfg.disk_en && !aen_s2 && hit_alt && !excl;
   always_comb begin
      unique case (cfg.aux_size)
         HDG_BLK_1: aux_mask = 10'h3ff;
         HDG_BLK_8: aux_mask = 10'h3f8;
         HDG_BLK_16: aux_mask = 10'h3f0;
         default: aux_mask = 10'h000;
      endcase
   end
   assign aux_hit = ((addr_s2 & aux_mask) == (cfg.aux_base & aux_mask))
                    && (aux_mask != 10'h000) && (cfg.aux_base != 10'h000);
   assign aux_dec = cfg.aux_en && !aen_s2 && aux_hit;
   // Decode outputs float while power invalid
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         disk_if_enable_n <= '{o: 1'b1, oe: 1'b0};
         disk_cs_ctrl_n <= '{o: 1'b1, oe: 1'b0};
         disk_cs_altstat_n <= '{o: 1'b1, oe: 1'b0};
         aux_block_decode_n <= '{o: 1'b1, oe: 1'b0};
      end else begin
         disk_if_enable_n <= '{o: !(cs_ctrl || cs_alt), oe: pv_s2};
         disk_cs_ctrl_n <= '{o: !cs_ctrl, oe: pv_s2};
         disk_cs_altstat_n <= '{o: !cs_alt, oe: pv_s2};
         // Open drain: drive only the low level
         aux_block_decode_n <= '{o: 1'b0, oe: pv_s2 && aux_dec};
      end
   end
   // Serial interrupts bypass the power gate
   genvar g;
   generate
      for (g = 0; g < HDG_NUM_IRQ; g++) begin : g_line
         logic alive;
         always_comb begin
            sel_req[g] = 1'b0;
            line_used[g] = 1'b1;
            alive = pv_s2;
            if (irq_route[g] == HDG_ROUTE_NONE) begin
               line_used[g] = 1'b0;
            end else if (irq_route[g] == HDG_ROUTE_EXT) begin
               sel_req[g] = ext_s2;
            end else if (irq_route[g] <= 4'h8) begin
               sel_req[g] = func_irq[3'(irq_route[g] - 4'h1)];
               alive = pv_s2 || serial_irq_mask[3'(irq_route[g] - 4'h1)];
            end else begin
               line_used[g] = 1'b0;
            end
         end
         hdg_irq_pulse u_pulse (
            .clk(clk),
            .rst_n(rst_n),
            .shared_mode(cfg.par_shared && irq_route[g] == 4'h1),
            .req(sel_req[g] && alive),
            .pin(shaped[g])
         );
         assign irq_line[g].o = shaped[g].o;
         assign irq_line[g].oe = shaped[g].oe && line_used[g] && alive;
      end
   endgenerate
   assign low_power = !pv_s2;
   // Ring indicate stays sampled whatever the power state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ring_seen <= 1'b0;
      end else begin
         ring_seen <= ri_s2;
      end
   end
   a_decode_excl: assert property (@(posedge clk) disable iff (!rst_n)
      $past(excl) |-> disk_cs_ctrl_n.o && disk_cs_altstat_n.o)
      else $error("decode of excluded address");
   a_disk_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !disk_if_enable_n.o |-> $past(cfg.disk_en) && !$past(aen_s2))
      else $error("disk enable without function enabled");
   a_ctrl_sel: assert property (@(posedge clk) disable iff (!rst_n)
      $past(cs_ctrl) |-> !disk_cs_ctrl_n.o && !disk_if_enable_n.o)
      else $error("control select missed");
   a_alt_sel: assert property (@(posedge clk) disable iff (!rst_n)
      $past(cs_alt) |-> !disk_cs_altstat_n.o)
      else $error("alternate status select missed");
   a_aux_block: assert property (@(posedge clk) disable iff (!rst_n)
      aux_block_decode_n.oe |-> $past(cfg.aux_en) && $past(aux_hit))
      else $error("aux decode outside block");
   a_power_float: assert property (@(posedge clk) disable iff (!rst_n)
      !pv_s2 ##1 !pv_s2 |-> !disk_cs_ctrl_n.oe && !aux_block_decode_n.oe)
      else $error("output driven while power invalid");
   a_route_ext: assert property (@(posedge clk) disable iff (!rst_n)
      irq_route[0] == HDG_ROUTE_EXT && !cfg.par_shared && pv_s2
      |-> irq_line[0].o == ext_s2 && irq_line[0].oe)
      else $error("external interrupt not steered");
   a_ext_float: assert property (@(posedge clk) disable iff (!rst_n)
      !pv_s2 && irq_route[0] == HDG_ROUTE_EXT |-> !irq_line[0].oe)
      else $error("external interrupt line driven while power invalid");
   a_func_route: assert property (@(posedge clk) disable iff (!rst_n)
      irq_route[3] == 4'h3 && pv_s2 |-> irq_line[3].o == func_irq[2] && irq_line[3].oe)
      else $error("function interrupt not steered");
   a_serial_alive: assert property (@(posedge clk) disable iff (!rst_n)
      irq_route[2] == 4'h2 && serial_irq_mask[1] && func_irq[1]
      |-> irq_line[2].o && irq_line[2].oe)
      else $error("serial interrupt lost");
   // Mode must hold one cycle ahead so the pulse edge detector starts clean
   sequence s_par_mode;
      cfg.par_shared && irq_route[0] == 4'h1 && pv_s2;
   endsequence
   sequence s_par_low;
      irq_line[0].oe && !irq_line[0].o;
   endsequence
   a_par_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      s_par_mode ##1 s_par_mode ##0 $rose(func_irq[0]) ##1 s_par_mode
      |-> s_par_low)
      else $error("shared parallel interrupt not pulsed low");
   a_if_float: assert property (@(posedge clk) disable iff (!rst_n)
      !pv_s2 ##1 !pv_s2 |-> !disk_if_enable_n.oe && !disk_cs_altstat_n.oe)
      else $error("disk enable driven while power invalid");
   a_aux_float: assert property (@(posedge clk) disable iff (!rst_n)
      !pv_s2 |=> !aux_block_decode_n.oe)
      else $error("aux decode driven while power invalid");
   a_aen_block: assert property (@(posedge clk) disable iff (!rst_n)
      $past(aen_s2) |-> disk_if_enable_n.o && disk_cs_ctrl_n.o && disk_cs_altstat_n.o)
      else $error("disk decode during a dma cycle");
   a_unrouted: assert property (@(posedge clk) disable iff (!rst_n)
      irq_route[7] == HDG_ROUTE_NONE |-> !irq_line[7].oe)
      else $error("unrouted line driven");
   a_ring_alive: assert property (@(posedge clk) disable iff (!rst_n)
      ri_s2 ##1 1'b1 |-> ring_seen)
      else $error("ring indicate lost");
   a_retain: assert property (@(posedge clk) disable iff (!rst_n)
      !pv_s2 |=> $stable(addr_s2))
      else $error("state changed while power invalid");
endmodule : hdg_glue

// ===== dv/hdg_far_model.sv
// Board-side model of the lines that the glue block drives toward the host
`timescale 1ns/1ns
module hdg_far_model (
   // Pins from the glue block
   input hdg_pkg::hdg_pin_t [7:0] irq_line,
   input hdg_pkg::hdg_pin_t aux_pin,
   // Resolved wire levels
   output logic [7:0] irq_wire,
   output logic aux_wire
);
   import hdg_pkg::*;
   // Released lines rise to the board pull-up, so a stale level never lingers
   always_comb begin
      for (int g = 0; g < HDG_NUM_IRQ; g++) begin
         irq_wire[g] = irq_line[g].oe ? irq_line[g].o : 1'b1;
      end
      aux_wire = aux_pin.oe ? aux_pin.o : 1'b1;
   end
endmodule : hdg_far_model

// ===== dv/tb_top.sv
// Self-checking testbench for the host decode and interrupt glue block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
   import hdg_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_valid = 1'b1;
   hdg_hbus_t hbus = '0;
   hdg_cfg_t cfg = '0;
   logic [7:0][3:0] irq_route = '0;
   logic [7:0] func_irq = '0;
   logic ext_interrupt_in = 1'b0;
   logic ring_indicate = 1'b0;
   logic [7:0] serial_irq_mask = '0;
   hdg_pin_t disk_if_enable_n, disk_cs_ctrl_n, disk_cs_altstat_n, aux_block_decode_n;
   hdg_pin_t [7:0] irq_line;
   logic low_power, ring_seen, aux_wire;
   logic [7:0] irq_wire;
   int sz[3] = '{1, 8, 16};
   int n_mismatch = 0;
   int samples_checked = 0;
   // Same 10 ns period as HDG_CLK_NS; the block counts cycles, not time
   always #5 clk = ~clk;
   hdg_glue dut_u (.clk(clk), .rst_n(rst_n), .power_valid(power_valid), .hbus(hbus),
      .cfg(cfg), .irq_route(irq_route), .func_irq(func_irq),
      .ext_interrupt_in(ext_interrupt_in), .ring_indicate(ring_indicate),
      .serial_irq_mask(serial_irq_mask), .disk_if_enable_n(disk_if_enable_n),
      .disk_cs_ctrl_n(disk_cs_ctrl_n), .disk_cs_altstat_n(disk_cs_altstat_n),
      .aux_block_decode_n(aux_block_decode_n), .irq_line(irq_line),
      .low_power(low_power), .ring_seen(ring_seen));
   hdg_far_model far_u (.irq_line(irq_line), .aux_pin(aux_block_decode_n),
      .irq_wire(irq_wire), .aux_wire(aux_wire));
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // Address passes two sync flops and an output register
   task automatic host_io(input logic [9:0] a, input logic aen);
      hbus.addr = a;
      hbus.aen = aen;
      settle(4);
   endtask : host_io
   task automatic chk_disk(input logic c, input logic s);
      `CHK("cs_ctrl", c, disk_cs_ctrl_n.o)
      `CHK("cs_alt", s, disk_cs_altstat_n.o)
      `CHK("if_en", c & s, disk_if_enable_n.o)
   endtask : chk_disk
   initial begin
      #50000;
      n_mismatch++;
      conclude();
   end
   initial begin
      settle(6);
      rst_n = 1'b1;
      settle(3);
      cfg.disk_en = 1'b1;
      cfg.disk_base1 = 10'h1f0;
      cfg.disk_base2 = 10'h3f0;
      for (int i = 0; i < 8; i++) begin
         host_io(10'h1f0 + 10'(i), 1'b0);
         chk_disk(1'b0, 1'b1);
      end
      host_io(10'h1f8, 1'b0);
      chk_disk(1'b1, 1'b1);
      host_io(10'h3f6, 1'b0);
      chk_disk(1'b1, 1'b0);
      host_io(10'h3f6, 1'b1);
      chk_disk(1'b1, 1'b1);
      cfg.disk_base1 = 10'h370;
      host_io(10'h377, 1'b0);
      chk_disk(1'b1, 1'b1);
      host_io(10'h376, 1'b0);
      chk_disk(1'b0, 1'b1);
      cfg.disk_base1 = 10'h3f0;
      host_io(10'h3f7, 1'b0);
      chk_disk(1'b1, 1'b1);
      cfg.disk_en = 1'b0;
      host_io(10'h3f1, 1'b0);
      chk_disk(1'b1, 1'b1);
      cfg.aux_en = 1'b1;
      cfg.aux_base = 10'h2a0;
      for (int k = 0; k < 3; k++) begin
         cfg.aux_size = hdg_blk_t'(k);
         host_io(10'h2a0 + 10'(sz[k] - 1), 1'b0);
         `CHK("aux_hit", 1'b0, aux_wire)
         host_io(10'h2a0 + 10'(sz[k]), 1'b0);
         `CHK("aux_miss", 1'b1, aux_wire)
      end
      ext_interrupt_in = 1'b1;
      for (int g = 0; g < 8; g++) begin
         irq_route = '0;
         irq_route[g] = HDG_ROUTE_EXT;
         settle(4);
         `CHK("ext_line", 2'b11, irq_line[g])
         `CHK("idle_oe", 1'b0, irq_line[(g + 1) % 8].oe)
      end
      ext_interrupt_in = 1'b0;
      settle(4);
      `CHK("ext_low", 1'b0, irq_wire[7])
      irq_route = '0;
      irq_route[3] = 4'h3;
      func_irq = 8'h04;
      settle(2);
      `CHK("func_line", 2'b11, irq_line[3])
      func_irq = '0;
      cfg.par_shared = 1'b1;
      irq_route[0] = 4'h1;
      settle(2);
      func_irq[0] = 1'b1;
      settle(2);
      `CHK("pulse_on", 2'b01, irq_line[0])
      settle(8);
      `CHK("pulse_last", 2'b01, irq_line[0])
      settle(1);
      `CHK("pulse_off", 1'b0, irq_line[0].oe)
      serial_irq_mask = 8'h02;
      irq_route[2] = 4'h2;
      func_irq[1] = 1'b1;
      ring_indicate = 1'b1;
      power_valid = 1'b0;
      host_io(10'h1f0, 1'b0);
      `CHK("low_power", 1'b1, low_power)
      `CHK("float_oe", 1'b0, disk_cs_ctrl_n.oe | irq_line[3].oe)
      `CHK("serial_alive", 2'b11, irq_line[2])
      `CHK("ring_seen", 1'b1, ring_seen)
      // New address while asleep must not reach the decoder
      hbus.addr = 10'h1f8;
      cfg.disk_en = 1'b1;
      cfg.disk_base1 = 10'h1f0;
      settle(3);
      power_valid = 1'b1;
      settle(4);
      chk_disk(1'b0, 1'b1);
      `CHK("oe_back", 1'b1, disk_cs_ctrl_n.oe)
      settle(2);
      chk_disk(1'b1, 1'b1);
      conclude();
   end
endmodule : tb_top
